// file: dmacc_top.v
// Contract
// - Eight channels, each with five 16-bit registers and a 10-bit count register.
// - Control bit 15 enables the channel to answer transfer requests.
// - Control bit 14 picks byte transfers when set, word transfers when clear.
// - Control bit 13 set moves RAM to peripheral, clear moves peripheral to RAM.
// - Control bit 12 raises the block interrupt at half block instead of end.
// - Control bit 11 adds a dummy peripheral write; software uses it only with direction 0.
// - Control bits 5-4 pick post-increment, fixed, or peripheral indirect addressing.
// - Control bits 1-0 pick continuous, one-shot, ping-pong continuous or ping-pong one-shot.
// - Control bits 10-6 and 3-2 ignore writes and read zero.
// - Writing 1 to request bit 15 starts one manual transfer.
// - Writing 0 leaves the force bit; hardware clears it after the transfer.
// - Request bits 6-0 pick one of 128 request lines; bits 14-7 read zero.
// - Primary base holds a 16-bit RAM start offset for primary blocks.
// - Secondary base holds a 16-bit RAM start offset for secondary blocks.
// - Peripheral target holds the 16-bit peripheral address of every transfer.
// - Count occupies bits 9-0, upper bits read zero; a block is count plus one transfers.
// - Each channel pulses its interrupt at block end or at half block.
// - Continuous modes reload the start address after each block and go on.
// - Ping-pong modes alternate primary and secondary start addresses per block.
// - One-shot modes stop after one block, or one block per buffer in ping-pong.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "dmacc_consts.vh"

module dmacc_top (
  input wire aclk,
  input wire aresetn,
  input wire [`DMACC_AW-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`DMACC_AW-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [127:0] peripheral_request_line,
  input wire [15:0] periph_indirect_offset,
  output wire xfer_valid,
  input wire xfer_ready,
  output wire [2:0] xfer_channel,
  output wire [15:0] xfer_ram_addr,
  output wire [15:0] xfer_periph_addr,
  output wire xfer_to_periph,
  output wire xfer_byte,
  output wire xfer_dummy_write,
  output wire [`DMACC_NCH-1:0] block_irq
);

  // Byte-lane merge of a bus write into a 16-bit register.
  function [15:0] wmerge;
    input [15:0] old;
    input [31:0] d;
    input [3:0] s;
    begin
      wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction
  reg aw_full_q;
  reg [`DMACC_AW-1:0] awaddr_q;
  reg w_full_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [1:0] rresp_q;
  reg [31:0] rdata_q;
  reg xfer_valid_q;
  reg [2:0] xfer_channel_q;
  reg [15:0] xfer_ram_addr_q;
  reg [15:0] xfer_periph_addr_q;
  reg xfer_to_periph_q;
  reg xfer_byte_q;
  reg xfer_dummy_q;
  wire wr_fire;
  wire [2:0] wr_ch;
  wire [2:0] wr_reg;
  wire [2:0] rd_reg;
  wire [2:0] rd_ch;
  wire [`DMACC_NCH-1:0] ch_pend;
  wire [`DMACC_NCH*16-1:0] ch_ram;
  wire [`DMACC_NCH*16-1:0] ch_pad;
  wire [`DMACC_NCH*3-1:0] ch_attr;
  wire [`DMACC_NCH*32-1:0] ch_rd;
  reg [2:0] gnt;
  reg gnt_any;
  integer i;
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // A write is performed only once both halves are held and the previous
  // response has been accepted, so one write is under way at a time.
  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_ch = awaddr_q[`DMACC_CH_LSB+2:`DMACC_CH_LSB];
  assign wr_reg = awaddr_q[`DMACC_REG_LSB+2:`DMACC_REG_LSB];
  assign rd_ch = s_axi_araddr[`DMACC_CH_LSB+2:`DMACC_CH_LSB];
  assign rd_reg = s_axi_araddr[`DMACC_REG_LSB+2:`DMACC_REG_LSB];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      awaddr_q <= {`DMACC_AW{1'b0}};
      w_full_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `DMACC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_reg > `DMACC_REG_STAT) ? `DMACC_RESP_SLVERR : `DMACC_RESP_OKAY;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= `DMACC_RESP_OKAY;
      rdata_q <= 32'h00000000;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= (rd_reg > `DMACC_REG_STAT) ? `DMACC_RESP_SLVERR : `DMACC_RESP_OKAY;
      rdata_q <= ch_rd[rd_ch*32 +: 32];
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < `DMACC_NCH; gi = gi + 1)
    begin : g_ch
      reg [15:0] ctrl_q;
      reg [15:0] req_q;
      reg [15:0] sta_q;
      reg [15:0] stb_q;
      reg [15:0] pad_q;
      reg [15:0] cnt_q;
      reg [15:0] addr_q;
      reg [9:0] idx_q;
      reg pp_q;
      reg pend_q;
      reg trig_prev_q;
      reg irq_q;
      wire sel_w;
      wire trig_w;
      wire done_w;
      wire last_w;
      wire half_w;
      wire [1:0] addressing_select_w;
      wire [15:0] base_w;
      wire [15:0] step_w;
      wire [15:0] ctrl_d;
      wire [15:0] req_d;

      assign sel_w = wr_fire & (wr_ch == gi);
      assign trig_w = peripheral_request_line[req_q[`DMACC_REQ_SEL_HI:0]];
      assign done_w = xfer_valid_q & xfer_ready & (xfer_channel_q == gi);
      assign last_w = idx_q == cnt_q[9:0];
      assign half_w = idx_q == {1'b0, cnt_q[9:1]};
      assign addressing_select_w = ctrl_q[`DMACC_CTRL_AM_HI:`DMACC_CTRL_AM_LO];
      assign base_w = pp_q ? stb_q : sta_q;
      assign step_w = ctrl_q[`DMACC_CTRL_SIZE] ? `DMACC_STEP_BYTE : `DMACC_STEP_WORD;
      assign ctrl_d = wmerge(ctrl_q, wdata_q, wstrb_q) & `DMACC_CTRL_MASK;
      assign req_d = wmerge(req_q, wdata_q, wstrb_q) & `DMACC_REQ_MASK;

      // A forced transfer takes the place of automatic requests until it ends.
      assign ch_pend[gi] = ctrl_q[`DMACC_CTRL_EN] & (pend_q | req_q[`DMACC_REQ_FORCE]);
      assign ch_ram[gi*16 +: 16] = (addressing_select_w == `DMACC_AM_PIND) ?
                                   (base_w | periph_indirect_offset) : addr_q;
      assign ch_pad[gi*16 +: 16] = pad_q;
      // Dummy writes are only meaningful towards RAM, so they are gated by direction.
      assign ch_attr[gi*3 +: 3] = {ctrl_q[`DMACC_CTRL_DIR], ctrl_q[`DMACC_CTRL_SIZE],
                                   ctrl_q[`DMACC_CTRL_DUMMY_PERIPHERAL_WRITE] & ~ctrl_q[`DMACC_CTRL_DIR]};
      assign block_irq[gi] = irq_q;
      assign ch_rd[gi*32 +: 32] =
        (rd_reg == `DMACC_REG_CTRL) ? {16'h0000, ctrl_q} :
        (rd_reg == `DMACC_REG_REQ) ? {16'h0000, req_q} :
        (rd_reg == `DMACC_REG_STA) ? {16'h0000, sta_q} :
        (rd_reg == `DMACC_REG_STB) ? {16'h0000, stb_q} :
        (rd_reg == `DMACC_REG_PAD) ? {16'h0000, pad_q} :
        (rd_reg == `DMACC_REG_CNT) ? {16'h0000, cnt_q} :
        (rd_reg == `DMACC_REG_STAT) ? {6'h00, idx_q, 13'h0000, pp_q, pend_q, ch_pend[gi]} :
        32'h00000000;

      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          ctrl_q <= `DMACC_RST16;
          req_q <= `DMACC_RST16;
          sta_q <= `DMACC_RST16;
          stb_q <= `DMACC_RST16;
          pad_q <= `DMACC_RST16;
          cnt_q <= `DMACC_RST16;
          addr_q <= `DMACC_RST16;
          idx_q <= 10'h000;
          pp_q <= 1'b0;
          pend_q <= 1'b0;
          trig_prev_q <= 1'b0;
          irq_q <= 1'b0;
        end
        else
        begin
          trig_prev_q <= trig_w;
          irq_q <= 1'b0;
          if (done_w)
          begin
            pend_q <= 1'b0;
            req_q[`DMACC_REQ_FORCE] <= 1'b0;
            if (ctrl_q[`DMACC_CTRL_HALF] ? half_w : last_w)
            begin
              irq_q <= 1'b1;
            end
            if (last_w)
            begin
              idx_q <= 10'h000;
              if (ctrl_q[`DMACC_CTRL_MODE_PP])
              begin
                pp_q <= ~pp_q;
                addr_q <= pp_q ? sta_q : stb_q;
              end
              else
              begin
                addr_q <= sta_q;
              end
              if (ctrl_q[`DMACC_CTRL_MODE_ONE] & (~ctrl_q[`DMACC_CTRL_MODE_PP] | pp_q))
              begin
                ctrl_q[`DMACC_CTRL_EN] <= 1'b0;
              end
            end
            else
            begin
              idx_q <= idx_q + 10'h001;
              if (addressing_select_w == `DMACC_AM_INC)
              begin
                addr_q <= addr_q + step_w;
              end
            end
          end
          // A new request edge wins over the clear of the one just served.
          if (ctrl_q[`DMACC_CTRL_EN] && trig_w && !trig_prev_q && !req_q[`DMACC_REQ_FORCE])
          begin
            pend_q <= 1'b1;
          end
          if (sel_w)
          begin
            case (wr_reg)
              `DMACC_REG_CTRL:
              begin
                ctrl_q <= ctrl_d;
                // Enabling restarts the block from the primary buffer.
                if (ctrl_d[`DMACC_CTRL_EN] && !ctrl_q[`DMACC_CTRL_EN])
                begin
                  addr_q <= sta_q;
                  idx_q <= 10'h000;
                  pp_q <= 1'b0;
                  pend_q <= 1'b0;
                end
              end
              `DMACC_REG_REQ:
              begin
                req_q[`DMACC_REQ_SEL_HI:0] <= req_d[`DMACC_REQ_SEL_HI:0];
                if (wstrb_q[1] && wdata_q[`DMACC_REQ_FORCE])
                begin
                  req_q[`DMACC_REQ_FORCE] <= 1'b1;
                end
              end
              `DMACC_REG_STA:
              begin
                sta_q <= wmerge(sta_q, wdata_q, wstrb_q);
              end
              `DMACC_REG_STB:
              begin
                stb_q <= wmerge(stb_q, wdata_q, wstrb_q);
              end
              `DMACC_REG_PAD:
              begin
                pad_q <= wmerge(pad_q, wdata_q, wstrb_q);
              end
              `DMACC_REG_CNT:
              begin
                cnt_q <= wmerge(cnt_q, wdata_q, wstrb_q) & `DMACC_CNT_MASK;
              end
              default: ;
            endcase
          end
        end
      end
    end
  endgenerate

  // Fixed priority: the lowest numbered pending channel is served first.
  always @*
  begin
    gnt = 3'h0;
    gnt_any = 1'b0;
    for (i = `DMACC_NCH - 1; i >= 0; i = i - 1)
    begin
      if (ch_pend[i])
      begin
        gnt = i[2:0];
        gnt_any = 1'b1;
      end
    end
  end

  // One transfer is outstanding at a time; its attributes are captured when
  // it is issued so that register writes cannot disturb it in flight.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xfer_valid_q <= 1'b0;
      xfer_channel_q <= 3'h0;
      xfer_ram_addr_q <= 16'h0000;
      xfer_periph_addr_q <= 16'h0000;
      xfer_to_periph_q <= 1'b0;
      xfer_byte_q <= 1'b0;
      xfer_dummy_q <= 1'b0;
    end
    else if (!xfer_valid_q)
    begin
      if (gnt_any)
      begin
        xfer_valid_q <= 1'b1;
        xfer_channel_q <= gnt;
        xfer_ram_addr_q <= ch_ram[gnt*16 +: 16];
        xfer_periph_addr_q <= ch_pad[gnt*16 +: 16];
        xfer_to_periph_q <= ch_attr[gnt*3 + 2];
        xfer_byte_q <= ch_attr[gnt*3 + 1];
        xfer_dummy_q <= ch_attr[gnt*3];
      end
    end
    else if (xfer_ready)
    begin
      xfer_valid_q <= 1'b0;
    end
  end

  assign xfer_valid = xfer_valid_q;
  assign xfer_channel = xfer_channel_q;
  assign xfer_ram_addr = xfer_ram_addr_q;
  assign xfer_periph_addr = xfer_periph_addr_q;
  assign xfer_to_periph = xfer_to_periph_q;
  assign xfer_byte = xfer_byte_q;
  assign xfer_dummy_write = xfer_dummy_q;

endmodule // dmacc_top

// file: dmacc_consts.vh
`ifndef DMACC_CONSTS_VH
`define DMACC_CONSTS_VH

// Channel count and register bus geometry.
`define DMACC_NCH 8
`define DMACC_AW 8
`define DMACC_CH_LSB 5
`define DMACC_REG_LSB 2

// Register index inside a channel window; byte offset is index times four.
`define DMACC_REG_CTRL 3'h0
`define DMACC_REG_REQ 3'h1
`define DMACC_REG_STA 3'h2
`define DMACC_REG_STB 3'h3
`define DMACC_REG_PAD 3'h4
`define DMACC_REG_CNT 3'h5
`define DMACC_REG_STAT 3'h6

// Reset value of every implemented channel register bit.
`define DMACC_RST16 16'h0000

// channel_control fields.
`define DMACC_CTRL_EN 15
`define DMACC_CTRL_SIZE 14
`define DMACC_CTRL_DIR 13
`define DMACC_CTRL_HALF 12
`define DMACC_CTRL_DUMMY_PERIPHERAL_WRITE 11
`define DMACC_CTRL_AM_HI 5
`define DMACC_CTRL_AM_LO 4
`define DMACC_CTRL_MODE_PP 1
`define DMACC_CTRL_MODE_ONE 0
`define DMACC_CTRL_MASK 16'hf833
`define DMACC_AM_INC 2'h0
`define DMACC_AM_FIX 2'h1
`define DMACC_AM_PIND 2'h2

// request_select fields.
`define DMACC_REQ_FORCE 15
`define DMACC_REQ_SEL_HI 6
`define DMACC_REQ_MASK 16'h007f

// transfer_count field.
`define DMACC_CNT_MASK 16'h03ff

// Address steps for post-increment.
`define DMACC_STEP_BYTE 16'h0001
`define DMACC_STEP_WORD 16'h0002

// AXI responses.
`define DMACC_RESP_OKAY 2'h0
`define DMACC_RESP_SLVERR 2'h2

`endif

// file: dmacc_properties.sv
`timescale 1ns/1ps
`include "dmacc_consts.vh"
module dmacc_properties (
  input wire aclk,
  input wire aresetn,
  input wire [`DMACC_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire xfer_valid,
  input wire xfer_ready,
  input wire [15:0] xfer_ram_addr,
  input wire xfer_to_periph,
  input wire xfer_dummy_write,
  input wire [`DMACC_NCH-1:0] block_irq
);
  // The read address is remembered so that read data can be judged per register.
  reg [2:0] ar_idx_q;
  always @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      ar_idx_q <= s_axi_araddr[4:2];
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  a_read_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken while one is answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before it was taken");
  a_xfer_hold: assert property (
    xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_ram_addr))
    else $error("transfer offer changed before completion");
  a_ctrl_zero: assert property (
    s_axi_rvalid && ar_idx_q == `DMACC_REG_CTRL |-> (s_axi_rdata & ~32'h0000f833) == 32'h0)
    else $error("unimplemented control bits read nonzero");
  a_req_zero: assert property (
    s_axi_rvalid && ar_idx_q == `DMACC_REG_REQ |-> (s_axi_rdata & ~32'h0000807f) == 32'h0)
    else $error("unimplemented request select bits read nonzero");
  a_cnt_zero: assert property (
    s_axi_rvalid && ar_idx_q == `DMACC_REG_CNT |-> s_axi_rdata[31:10] == 22'h0)
    else $error("count upper bits read nonzero");
  a_unmapped_err: assert property (
    s_axi_rvalid && ar_idx_q == 3'h7 |-> s_axi_rresp == `DMACC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_dummy_dir: assert property (xfer_valid && xfer_dummy_write |-> !xfer_to_periph)
    else $error("dummy write offered on a transfer to the peripheral");
  a_irq_cause: assert property (
    block_irq != 8'h0 |-> $past(xfer_valid) && $past(xfer_ready))
    else $error("block interrupt without a completed transfer");
  c_xfer: cover property (xfer_valid && xfer_ready);
  c_irq: cover property (block_irq != 8'h0);
  c_unmapped: cover property (s_axi_rvalid && ar_idx_q == 3'h7);
endmodule // dmacc_properties

bind dmacc_top dmacc_properties u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_ram_addr(xfer_ram_addr),
  .xfer_to_periph(xfer_to_periph), .xfer_dummy_write(xfer_dummy_write), .block_irq(block_irq));

// file: dmacc_partner.sv
`timescale 1ns/1ps
module dmacc_partner (
  input wire aclk,
  input wire aresetn,
  input wire xfer_valid,
  output reg xfer_ready
);
  integer seed = 32'he0455607;
  // Ready wanders freely, with or without an offer, so both prompt and stalled completions occur.
  always @(posedge aclk)
  begin
    if (!aresetn)
      xfer_ready <= 1'h0;
    else
      xfer_ready <= ($random(seed) & 3) != 0;
  end
endmodule // dmacc_partner

// file: dmacc_tb.sv
`timescale 1ns/1ps
`include "dmacc_consts.vh"
module testbench;
  reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, d;
  reg [127:0] req_lines;
  reg [15:0] ind_off;
  wire awready, wready, bvalid, arready, rvalid, xv, xr, xtp, xb, xd;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] xch;
  wire [15:0] xra, xpa;
  wire [7:0] irq;
  integer n_errors, checks, seed, cyc, n_xf, i, m, k, j;
  integer irq_n [0:7];
  logic [15:0] mexp [0:5] = '{16'h7833, 16'h007f, 16'h7fff, 16'h7fff, 16'h7fff, 16'h03ff};
  integer irq_exp [0:7] = '{2, 1, 1, 0, 2, 0, 0, 0};
  logic [33:0] rq [$];
  logic [37:0] xq [$];

  dmacc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .peripheral_request_line(req_lines),
    .periph_indirect_offset(ind_off), .xfer_valid(xv), .xfer_ready(xr),
    .xfer_channel(xch), .xfer_ram_addr(xra), .xfer_periph_addr(xpa),
    .xfer_to_periph(xtp), .xfer_byte(xb), .xfer_dummy_write(xd), .block_irq(irq));
  dmacc_partner u_far (.aclk(aclk), .aresetn(aresetn), .xfer_valid(xv), .xfer_ready(xr));

  initial
  begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  task chk(input [63:0] seen, input [63:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      n_errors = n_errors + 1;
    end
  endtask

  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task wr(input [2:0] ch, input [2:0] idx, input [31:0] dv, input [1:0] er);
    reg ad, wd;
    @(posedge aclk);
    awaddr <= {ch, idx, 2'h0};
    wdata <= dv;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    ad = 1'h0;
    wd = 1'h0;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        awvalid <= 1'h0;
        ad = 1'h1;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'h0;
        wd = 1'h1;
      end
    end
    while (!bvalid) @(posedge aclk);
    chk(bresp, er);
    bready <= 1'h0;
  endtask

  task rd(input [2:0] ch, input [2:0] idx, input [33:0] e);
    @(posedge aclk);
    araddr <= {ch, idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    rq.push_back(e);
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h0;
  endtask

  task ex(input [2:0] ch, input [15:0] ra, input [15:0] pa, input [2:0] flags);
    xq.push_back({ch, ra, pa, flags});
  endtask

  // A new request is raised only after the previous one completed, since pending edges merge.
  task fire(input [6:0] ln);
    @(posedge aclk);
    req_lines[ln] <= 1'h1;
    k = n_xf;
    @(posedge aclk);
    req_lines[ln] <= 1'h0;
    while (n_xf == k) @(posedge aclk);
  endtask

  task frc(input [2:0] ch, input [31:0] ctl);
    k = n_xf;
    wr(ch, ctl[31] ? `DMACC_REG_CTRL : `DMACC_REG_REQ, {16'h0, ctl[15:0]}, `DMACC_RESP_OKAY);
    while (n_xf == k) @(posedge aclk);
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (aresetn && rvalid && rready)
      chk({rresp, rdata}, rq.size() ? rq.pop_front() : 34'h3ffffffff);
    if (aresetn && xv && xr)
    begin
      chk({xch, xra, xpa, xtp, xb, xd}, xq.size() ? xq.pop_front() : 38'h0);
      n_xf <= n_xf + 1;
    end
    for (j = 0; j < 8; j = j + 1)
      if (irq[j] === 1'h1)
        irq_n[j] <= irq_n[j] + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, req_lines} = 176'h0;
    ind_off = 16'h0006;
    {n_errors, checks, cyc, n_xf} = 128'h0;
    seed = 32'he0455607;
    for (i = 0; i < 8; i = i + 1)
      irq_n[i] = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (i = 0; i < 8; i = i + 1)
      for (m = 0; m < 6; m = m + 1)
        rd(i, m, 34'h0);
    for (m = 0; m < 6; m = m + 1)
      wr(3, m, 32'hffff7fff, `DMACC_RESP_OKAY);
    for (m = 0; m < 6; m = m + 1)
      rd(3, m, {18'h0, mexp[m]});
    for (m = 0; m < 6; m = m + 1)
    begin
      d = $random(seed);
      wr(6, 2 + m % 3, d, `DMACC_RESP_OKAY);
      rd(6, 2 + m % 3, {18'h0, d[15:0]});
    end
    wr(0, 7, 32'hffffffff, `DMACC_RESP_SLVERR);
    rd(0, 7, {`DMACC_RESP_SLVERR, 32'h0});
    // Base, target and count are set while each channel is still disabled.
    wr(0, `DMACC_REG_STA, 32'h1000, `DMACC_RESP_OKAY);
    wr(0, `DMACC_REG_STB, 32'h1800, `DMACC_RESP_OKAY);
    wr(0, `DMACC_REG_PAD, 32'h0200, `DMACC_RESP_OKAY);
    wr(0, `DMACC_REG_CNT, 32'h1, `DMACC_RESP_OKAY);
    wr(0, `DMACC_REG_REQ, 32'h5, `DMACC_RESP_OKAY);
    wr(0, `DMACC_REG_CTRL, 32'h8002, `DMACC_RESP_OKAY);
    for (m = 0; m < 5; m = m + 1)
    begin
      ex(0, (m % 4 < 2 ? 16'h1000 : 16'h1800) + 2 * (m % 2), 16'h0200, 3'h0);
      fire(5);
    end
    wr(1, `DMACC_REG_STA, 32'h2000, `DMACC_RESP_OKAY);
    wr(1, `DMACC_REG_PAD, 32'h0210, `DMACC_RESP_OKAY);
    wr(1, `DMACC_REG_CNT, 32'h3, `DMACC_RESP_OKAY);
    wr(1, `DMACC_REG_CTRL, 32'hf001, `DMACC_RESP_OKAY);
    for (m = 0; m < 4; m = m + 1)
    begin
      ex(1, 16'h2000 + m, 16'h0210, 3'h6);
      frc(1, 32'h8000);
    end
    rd(1, `DMACC_REG_CTRL, 34'h7001);
    rd(1, `DMACC_REG_REQ, 34'h0);
    wr(2, `DMACC_REG_REQ, 32'h8000, `DMACC_RESP_OKAY);
    rd(2, `DMACC_REG_REQ, 34'h8000);
    wr(2, `DMACC_REG_REQ, 32'h0, `DMACC_RESP_OKAY);
    rd(2, `DMACC_REG_REQ, 34'h8000);
    wr(2, `DMACC_REG_STA, 32'h3000, `DMACC_RESP_OKAY);
    wr(2, `DMACC_REG_PAD, 32'h0220, `DMACC_RESP_OKAY);
    wr(2, `DMACC_REG_CNT, 32'h1, `DMACC_RESP_OKAY);
    ex(2, 16'h3000, 16'h0220, 3'h1);
    frc(2, 32'h80008810);
    rd(2, `DMACC_REG_REQ, 34'h0);
    ex(2, 16'h3000, 16'h0220, 3'h1);
    frc(2, 32'h8000);
    wr(4, `DMACC_REG_STA, 32'h4000, `DMACC_RESP_OKAY);
    wr(4, `DMACC_REG_STB, 32'h5000, `DMACC_RESP_OKAY);
    wr(4, `DMACC_REG_PAD, 32'h0240, `DMACC_RESP_OKAY);
    wr(4, `DMACC_REG_CNT, 32'h1, `DMACC_RESP_OKAY);
    wr(4, `DMACC_REG_REQ, 32'h9, `DMACC_RESP_OKAY);
    wr(4, `DMACC_REG_CTRL, 32'h8023, `DMACC_RESP_OKAY);
    for (m = 0; m < 4; m = m + 1)
    begin
      ex(4, m < 2 ? 16'h4006 : 16'h5006, 16'h0240, 3'h0);
      fire(9);
    end
    rd(4, `DMACC_REG_CTRL, 34'h0023);
    // With the channel now off, this request must not produce a transfer.
    @(posedge aclk);
    req_lines[9] <= 1'h1;
    @(posedge aclk);
    req_lines[9] <= 1'h0;
    repeat (20) @(posedge aclk);
    for (m = 0; m < 8; m = m + 1)
      chk(irq_n[m], irq_exp[m]);
    tally_and_finish;
  end
endmodule // testbench
